/* File: src/wire_bus_port.sv */
// Single-wire bus engine with its Wishbone register file.
`timescale 1ns/1ps
`default_nettype none
`include "wire_bus_cfg.svh"
module wire_bus_port
  import wire_bus_pkg::*;
#(
  parameter int DIV_W = 13
) (
  input  wire logic        clk_i,       // System clock, also tick source.
  input  wire logic        rst_i,       // Synchronous reset, active high.
  input  wire logic [11:0] adr_i,       // Wishbone byte address.
  input  wire logic [31:0] dat_i,       // Wishbone write data.
  output logic      [31:0] dat_o,       // Wishbone read data.
  input  wire logic        we_i,        // Write enable.
  input  wire logic [3:0]  sel_i,       // Byte lane selects.
  input  wire logic        cyc_i,       // Bus cycle.
  input  wire logic        stb_i,       // Strobe.
  output logic             ack_o,       // Acknowledge.
  input  wire logic        wait_mode_i, // Chip is in wait mode.
  input  wire logic        wire_i,      // Level seen on the bus wire.
  output logic             wire_o,      // Drive value, always dominant.
  output logic             wire_oe_o,   // High while pulling wire low.
  output logic             irq_o        // Level interrupt request.
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic [DIV_W-1:0] baud_q;
  logic [DIV_W-1:0] div_cnt_q;
  mode_t            mode_q;
  logic             rie_q;
  logic             te_q;
  logic             re_q;
  logic [7:0]       tx_data_q;
  logic [7:0]       rx_data_q;
  logic [7:0]       shift_q;
  rx_flags_t        flags_q;
  rx_flags_t        snap_q;
  logic             armed_q;
  logic [2:0]       irq_st_q;
  logic [2:0]       irq_en_q;
  logic             ack_q;
  logic [31:0]      dat_q;
  wire_state_t      state_q;
  logic [3:0]       tick_cnt_q;
  logic             slot_q;
  logic [2:0]       bit_q;
  logic [2:0]       samp_q;
  logic             err_q;
  logic             oe_q;
  logic             raf_q;
  logic             irq_q;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] idx;

  // A request is taken once; ack_q masks the cycle in which it is given.
  assign acc = cyc_i & stb_i & ~ack_q;
  assign wr  = acc & we_i;
  assign rd  = acc & ~we_i;
  assign idx = adr_i[9:2];

  // Majority of three samples, used for the pull bit value.
  function automatic logic major3(input logic [2:0] s);
    major3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : major3

  // --------------------------------------------------------------------
  // Tick and slot timing
  // --------------------------------------------------------------------
  logic       halt_now;
  logic       tick;
  logic       slot_end;
  logic       start;
  logic       push_lvl;
  logic [3:0] samp_at;
  logic       pull_bit_end;
  logic       pull_done;
  logic       push_done;
  logic       mis_hit;
  logic       noise_hit;
  logic [7:0] rx_word;

  assign halt_now = mode_q.halt & wait_mode_i; // RULE4
  assign tick = (baud_q != '0) && !halt_now &&
                (div_cnt_q == baud_q - 1'b1); // RULE15
  assign slot_end = tick && (tick_cnt_q == `TICK_LAST); // RULE7
  assign start = wr && sel_i[0] && (idx == `IDX_DATA) &&
                 mode_q.wire_mode_enable && te_q && (state_q == ST_IDLE); // RULE5
  // Biphase: first slot carries the inverse, second slot the bit.
  assign push_lvl = slot_q ? tx_data_q[bit_q] : ~tx_data_q[bit_q];
  assign samp_at = `SYNC_TICKS + `DRIVE_LAG + {2'b00, mode_q.dly}; // RULE6
  assign pull_bit_end = (state_q == ST_PULL) && slot_end && slot_q;
  assign pull_done = pull_bit_end && (bit_q == `BIT_LAST);
  assign push_done = (state_q == ST_PUSH) && slot_end && slot_q &&
                     (bit_q == `BIT_LAST);
  assign mis_hit = (state_q == ST_PUSH) && tick &&
                   (tick_cnt_q == `TICK_SAMPLE) &&
                   (wire_i != push_lvl); // RULE1
  assign noise_hit = pull_bit_end && (samp_q != 3'b000) &&
                     (samp_q != 3'b111); // RULE3
  assign rx_word = {major3(samp_q), shift_q[7:1]}; // RULE11

  // Baud divider; a start realigns it so a field begins on a slot edge.
  always_ff @(posedge clk_i) begin
    if (rst_i || start || baud_q == '0) begin
      div_cnt_q <= '0;
    end else if (halt_now) begin
      div_cnt_q <= div_cnt_q; // RULE4
    end else if (tick) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // Sixteen ticks make one slot.
  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Field sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      slot_q  <= 1'b0;
      bit_q   <= '0;
    end else if (!mode_q.wire_mode_enable) begin
      state_q <= ST_IDLE; // RULE5
      slot_q  <= 1'b0;
      bit_q   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_PUSH;
            slot_q  <= 1'b0;
            bit_q   <= '0;
          end
        end
        ST_PUSH: begin
          if (slot_end) begin
            slot_q <= ~slot_q;
            if (slot_q) begin
              bit_q <= bit_q + 1'b1; // RULE12
              if (bit_q == `BIT_LAST) begin
                state_q <= re_q ? ST_PULL : ST_IDLE;
              end
            end
          end
        end
        ST_PULL: begin
          if (slot_end) begin
            slot_q <= ~slot_q;
            if (slot_q) begin
              bit_q <= bit_q + 1'b1;
              if (bit_q == `BIT_LAST) begin
                state_q <= ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Line drive: push levels, then a one-tick sync low at each pull bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_q <= 1'b0;
    end else if (state_q == ST_PUSH) begin
      oe_q <= ~push_lvl;
    end else if (state_q == ST_PULL) begin
      oe_q <= ~slot_q && (tick_cnt_q < `SYNC_TICKS);
    end else begin
      oe_q <= 1'b0;
    end
  end

  // Receiver active for the whole pull field only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raf_q <= 1'b0;
    end else begin
      raf_q <= (state_q == ST_PULL) && !pull_done; // RULE8
    end
  end

  // Three samples per pull bit, starting after the selected delay.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_q <= '0;
    end else if (state_q == ST_PULL && tick && !slot_q &&
                 tick_cnt_q >= samp_at &&
                 tick_cnt_q < samp_at + 4'h3) begin
      samp_q <= {samp_q[1:0], wire_i}; // RULE6
    end
  end

  // Shift in LSB first; a failed field reads as all ones.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q   <= '0;
      err_q     <= 1'b0;
      rx_data_q <= '0;
    end else if (start) begin
      err_q <= 1'b0;
    end else if (pull_bit_end) begin
      shift_q <= rx_word; // RULE11
      if (noise_hit) begin
        err_q <= 1'b1;
      end
      if (pull_done) begin
        if (err_q || noise_hit ||
            (rx_word & `PULL_MASK) != `PULL_PAT) begin // RULE9
          rx_data_q <= `PULL_ERR; // RULE10
        end else begin
          rx_data_q <= rx_word; // RULE9
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Status flags and clearing sequence
  // --------------------------------------------------------------------
  logic      clr_seq;
  rx_flags_t set_f;

  assign clr_seq = rd && (idx == `IDX_DATA) && armed_q; // RULE14
  assign set_f   = '{receive_full_flag: pull_done, bit_err: mis_hit, noise: noise_hit};

  // Snapshot at the status read; only those bits may clear later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_q  <= '0;
      armed_q <= 1'b0;
    end else if (rd && idx == `IDX_STAT1) begin
      snap_q  <= flags_q; // RULE14
      armed_q <= 1'b1;
    end else if (clr_seq) begin
      armed_q <= 1'b0;
    end
  end

  // New events win over the clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else if (clr_seq) begin
      flags_q <= (flags_q & ~snap_q) | set_f; // RULE14 RULE17
    end else begin
      flags_q <= flags_q | set_f; // RULE17
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_q    <= '0;
      mode_q    <= '0;
      rie_q     <= 1'b0;
      te_q      <= 1'b0;
      re_q      <= 1'b0;
      tx_data_q <= '0;
    end else if (wr) begin
      if (idx == `IDX_BAUD) begin
        if (sel_i[0]) begin
          baud_q[7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          baud_q[DIV_W-1:8] <= dat_i[DIV_W-1:8];
        end
      end else if (idx == `IDX_MODE && sel_i[0]) begin
        mode_q.halt <= dat_i[`S2_HALT];
        mode_q.wire_mode_enable  <= dat_i[`S2_MIE];
        mode_q.dly  <= dat_i[`S2_DLY_HI:`S2_DLY_LO];
      end else if (idx == `IDX_CTRL && sel_i[0]) begin
        rie_q <= dat_i[`C2_RIE];
        te_q  <= dat_i[`C2_TE];
        re_q  <= dat_i[`C2_RE];
      end else if (idx == `IDX_DATA && sel_i[0] && state_q == ST_IDLE) begin
        tx_data_q <= dat_i[7:0]; // RULE13
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  assign irq_set = {noise_hit, pull_done, push_done};
  assign irq_clr = (wr && sel_i[0] && idx == `IDX_IRQ_CLR) ?
                   dat_i[2:0] : 3'b000;

  // Sticky event bits; a set in the clear cycle survives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q <= '0;
      irq_en_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
      if (wr && sel_i[0] && idx == `IDX_IRQ_EN) begin
        irq_en_q <= dat_i[2:0];
      end
    end
  end

  // Mismatch is deliberately absent here so it can never interrupt.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|(irq_st_q & irq_en_q)) ||
               (rie_q && flags_q.receive_full_flag); // RULE2 RULE16
    end
  end

  // --------------------------------------------------------------------
  // Register reads and acknowledge
  // --------------------------------------------------------------------
  logic [31:0] rdata;

  always_comb begin
    rdata = '0;
    if (idx == `IDX_BAUD) begin
      rdata[DIV_W-1:0] = baud_q;
    end else if (idx == `IDX_MODE || idx == `IDX_STAT2) begin
      rdata[`S2_HALT] = mode_q.halt;
      rdata[`S2_MIE]  = mode_q.wire_mode_enable;
      rdata[`S2_DLY_HI:`S2_DLY_LO] = mode_q.dly;
      rdata[`S2_RAF]  = (idx == `IDX_STAT2) && raf_q; // RULE8
    end else if (idx == `IDX_CTRL) begin
      rdata[`C2_RIE] = rie_q;
      rdata[`C2_TE]  = te_q;
      rdata[`C2_RE]  = re_q;
    end else if (idx == `IDX_STAT1) begin
      rdata[`S1_RECEIVE_FULL_FLAG]   = flags_q.receive_full_flag;
      rdata[`S1_BITERR] = flags_q.bit_err;
      rdata[`S1_NOISE]  = flags_q.noise;
    end else if (idx == `IDX_DATA) begin
      rdata[7:0] = rx_data_q; // RULE13
    end else if (idx == `IDX_IRQ_ST) begin
      rdata[2:0] = irq_st_q;
    end else if (idx == `IDX_IRQ_EN) begin
      rdata[2:0] = irq_en_q;
    end
  end

  // One-cycle ack one edge after the request; unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= acc;
      if (rd) begin
        dat_q <= rdata;
      end
    end
  end

  assign dat_o     = dat_q;
  assign ack_o     = ack_q;
  assign wire_oe_o = oe_q;
  assign irq_o     = irq_q;

  // The drive value is constant; only the enable moves the wire.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wire_o <= 1'b0;
    end else begin
      wire_o <= 1'b0;
    end
  end

endmodule : wire_bus_port
`default_nettype wire

/* File: pkg/wire_bus_cfg.svh */
// Register indices, field positions and timing counts of the wire port.
`ifndef WIRE_BUS_CFG_SVH
`define WIRE_BUS_CFG_SVH
// ----------------------------------------------------------------------
// What this block does
// (RULE1) Set bit mismatch flag when the wire differs from a sent push bit.
// (RULE2) Bit mismatch flag never requests an interrupt in wire mode.
// (RULE3) Set noise flag when pull field samples disagree.
// (RULE4) Halt bit plus wait mode stops serial clock; otherwise clock runs.
// (RULE5) Mode enable selects wire behaviour; clear means normal serial use. Here clear only holds the sequencer idle so no field starts.
// (RULE6) Delay select 00..11 delays reception by 1..4 sixteenths of a slot.
// (RULE7) Two slots per bit, delay unit is one slot over sixteen.
// (RULE8) Receiver active flag is high only while a character is received.
// (RULE9) Valid pull word reads 0101 in bits 7..4, 1 in bit 0.
// (RULE10) A failed pull field reads back as all ones.
// (RULE11) Pull bits are assembled least significant bit first.
// (RULE12) Push sends data bits 4..0 first, then address bits 7..5.
// (RULE13) Data reads return receive register; writes load transmit register.
// (RULE14) Status read then data read clears only flags seen at status read.
// (RULE15) Tick is clock over divisor, 16 per slot; zero divisor stops it.
// (RULE16) Receive interrupt enable requests interrupt while receive full.
// (RULE17) Mismatch and noise flags hold until the clearing sequence.
// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
`define IDX_BAUD     8'hc0
`define IDX_MODE     8'hc2
`define IDX_CTRL     8'hc3
`define IDX_STAT1    8'hc4
`define IDX_STAT2    8'hc5
`define IDX_DATA     8'hc7
`define IDX_IRQ_ST   8'hd0
`define IDX_IRQ_CLR  8'hd1
`define IDX_IRQ_EN   8'hd2
// Field positions.
`define S2_HALT      7
`define S2_MIE       6
`define S2_DLY_HI    5
`define S2_DLY_LO    4
`define S2_RAF       0
`define S1_RECEIVE_FULL_FLAG      5
`define S1_BITERR    3
`define S1_NOISE     2
`define C2_RIE       5
`define C2_TE        3
`define C2_RE        2
`define IRQ_PUSH     0
`define IRQ_PULL     1
`define IRQ_NOISE    2
// Timing in ticks of sixteen per slot.
`define TICK_LAST    4'hf
`define TICK_SAMPLE  4'h8
`define SYNC_TICKS   4'h1
`define DRIVE_LAG    4'h1  // Registered drive shows on the wire a clock late.
`define BIT_LAST     3'h7
// Receive word pattern.
`define PULL_MASK    8'hf1
`define PULL_PAT     8'h51
`define PULL_ERR     8'hff
`endif

/* File: pkg/wire_bus_pkg.sv */
// Types shared by the single-wire bus port.
package wire_bus_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_PULL = 2'b10
  } wire_state_t;

  typedef struct packed {
    logic receive_full_flag;
    logic bit_err;
    logic noise;
  } rx_flags_t;

  typedef struct packed {
    logic       halt;
    logic       wire_mode_enable;
    logic [1:0] dly;
  } mode_t;
endpackage : wire_bus_pkg

/* File: sim/wire_bus_port_sva.sv */
// Port-level concurrent checks for the single-wire bus port.
`timescale 1ns/1ps
`default_nettype none
module wire_bus_port_sva #(
  parameter int DIV_W = 13
) (
  input  wire logic        clk_i,       // Clock.
  input  wire logic        rst_i,       // Synchronous reset.
  input  wire logic [11:0] adr_i,       // Byte address.
  input  wire logic [31:0] dat_i,       // Write data.
  input  wire logic [31:0] dat_o,       // Read data.
  input  wire logic        we_i,        // Write enable.
  input  wire logic [3:0]  sel_i,       // Byte lanes.
  input  wire logic        cyc_i,       // Bus cycle.
  input  wire logic        stb_i,       // Strobe.
  input  wire logic        ack_o,       // Acknowledge.
  input  wire logic        wait_mode_i, // Chip wait mode.
  input  wire logic        wire_i,      // Wire level.
  input  wire logic        wire_o,      // Drive value.
  input  wire logic        wire_oe_o,   // Drive enable.
  input  wire logic        irq_o        // Interrupt.
);
  logic [5:0] run_q;   // Length of the current drive pulse, saturating.
  logic       rd_take; // A read is taken at this edge.

  assign rd_take = cyc_i && stb_i && !we_i && !ack_o;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------------
  // Drive pulse length
  // ----------------------------------------------------------------------
  // Saturation marks frozen or aborted fields, which may run any length.
  always_ff @(posedge clk_i) begin
    if (rst_i || !wire_oe_o) begin
      run_q <= 6'h00;
    end else if (run_q != 6'h3f) begin
      run_q <= run_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged after one cycle");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_wire_dominant: assert property (wire_o == 1'b0)
    else $error("wire drive value is not dominant");
  a_reset_quiet: assert property ($fell(rst_i) |->
    !ack_o && !wire_oe_o && !irq_o && dat_o == 32'h0)
    else $error("outputs not quiet after reset");
  a_read_hold: assert property (!$past(rd_take) |-> $stable(dat_o))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (rd_take && adr_i[9:2] < 8'hc0 |=>
    dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_rx_word_form: assert property (rd_take && adr_i[9:2] == 8'hc7 |=>
    dat_o[31:8] == 24'h0 && (dat_o[7:0] inside {8'hff, 8'h00} ||
    (dat_o[7:0] & 8'hf1) == 8'h51))
    else $error("receive word has a bad form");
  a_pulse_length: assert property ($fell(wire_oe_o) |->
    run_q inside {6'd1, 6'd16, 6'd17, 6'd32, 6'h3f})
    else $error("wire drive pulse has a bad length");
endmodule : wire_bus_port_sva

bind wire_bus_port wire_bus_port_sva #(.DIV_W(DIV_W)) u_wire_bus_port_sva (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .wait_mode_i(wait_mode_i),
  .wire_i(wire_i), .wire_o(wire_o), .wire_oe_o(wire_oe_o), .irq_o(irq_o));
`default_nettype wire

/* File: sim/wire_slave_model.sv */
// Behavioural slave on the shared wire: answers each sync with one bit.
`timescale 1ns/1ps
`default_nettype none
module wire_slave_model (
  input  wire logic       clk_i,    // Clock.
  input  wire logic       rst_i,    // Reset.
  input  wire logic       dev_oe_i, // Port pulls the wire low.
  input  wire logic [7:0] resp_i,   // Pull word, bit 0 answered first.
  input  wire logic       noisy_i,  // Toggle the wire in each answer.
  input  wire logic       stuck_i,  // Hold the wire low throughout.
  output logic            wire_o    // Resolved wire level.
);
  logic [3:0] win_q;  // Cycles left in the answer window.
  logic [2:0] idx_q;  // Bit of the pull word being answered.
  logic       seen_q; // Port drive seen at the last edge.
  logic [4:0] len_q;  // Length of the current port drive pulse.
  logic       tog_q;  // Toggle used as noise.
  logic       sync;   // Port has just released a sync.
  logic       pull;   // Slave pulls the wire low.

  // A sync is a one-cycle pulse, or a 17-cycle one where it merges with a
  // dominant last push slot; push pulses never match, so never answer.
  assign sync = seen_q && !dev_oe_i && (len_q == 5'h01 || len_q == 5'h11);

  // The answer starts as the port releases the sync and fills the window.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q  <= 4'h0;
      idx_q  <= 3'h0;
      seen_q <= 1'b0;
      len_q  <= 5'h00;
      tog_q  <= 1'b0;
    end else begin
      seen_q <= dev_oe_i;
      tog_q  <= ~tog_q;
      if (!dev_oe_i) begin
        len_q <= 5'h00;
      end else if (len_q != 5'h1f) begin
        len_q <= len_q + 5'h01;
      end
      if (sync) begin
        win_q <= 4'hd;
      end else if (win_q != 4'h0) begin
        win_q <= win_q - 4'h1;
        if (win_q == 4'h1) idx_q <= idx_q + 3'h1;
      end
    end
  end

  // The pull-up holds the wire high once nobody pulls it.
  assign pull   = stuck_i || ((sync || win_q != 4'h0) &&
                  (noisy_i ? tog_q : !resp_i[idx_q]));
  assign wire_o = !(dev_oe_i || pull);
endmodule : wire_slave_model
`default_nettype wire

/* File: sim/wire_bus_port_tb.sv */
// Self-checking bench for the single-wire bus port.
`timescale 1ns/1ps
`default_nettype none
`include "wire_bus_cfg.svh"
module wire_bus_port_tb;
  logic        clk_i, rst_i, cyc, stb, we, wait_mode, noisy, stuck;
  logic        ack, wire_lvl, wire_oe, irq;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  resp;
  integer      n_errors, n_tests, seed;
  logic [7:0]  ro_regs [8];

  wire_bus_port u_wire_bus_port (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(4'h3), .cyc_i(cyc),
    .stb_i(stb), .ack_o(ack), .wait_mode_i(wait_mode), .wire_i(wire_lvl),
    .wire_o(), .wire_oe_o(wire_oe), .irq_o(irq));
  wire_slave_model u_wire_slave_model (.clk_i(clk_i), .rst_i(rst_i),
    .dev_oe_i(wire_oe), .resp_i(resp), .noisy_i(noisy), .stuck_i(stuck),
    .wire_o(wire_lvl));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One classic cycle; the answer is awaited, never assumed.
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {2'b00, idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) n_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  // The interrupt is registered, so let it settle first.
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask : irq_is

  // One push with its pull, checked against the bench model.
  task automatic field(input logic [7:0] tx, rsp, input logic nz, sk,
                       input logic [1:0] dly, input logic receive_interrupt_enable);
    logic [15:0] slots, exp_slots;
    logic [7:0]  md, word, rx;
    md   = {2'b01, dly, 4'h0};
    word = sk ? 8'h00 : rsp;
    rx   = ((word & `PULL_MASK) == `PULL_PAT && !nz) ? word : `PULL_ERR;
    for (int k = 0; k < 8; k++) exp_slots[2*k +: 2] = {~tx[k], tx[k]};
    resp  <= rsp;
    noisy <= nz;
    stuck <= sk;
    wb(1'b1, `IDX_IRQ_CLR, 32'h7);
    wb(1'b1, `IDX_MODE, {24'h0, md});
    wb(1'b1, `IDX_CTRL, {26'h0, receive_interrupt_enable, 5'b01100});
    wb(1'b1, `IDX_DATA, {24'h0, tx});
    repeat (7) @(posedge clk_i);
    for (int k = 0; k < 16; k++) begin
      slots[k] = wire_oe;
      repeat (16) @(posedge clk_i);
    end
    chk("push slots", {16'h0, slots}, {16'h0, exp_slots});
    repeat (120) @(posedge clk_i);
    wb(1'b0, `IDX_STAT2, 32'h0);
    chk("active", q, {24'h0, md | 8'h01});
    repeat (200) @(posedge clk_i);
    wb(1'b0, `IDX_STAT2, 32'h0);
    chk("idle", q, {24'h0, md});
    irq_is(receive_interrupt_enable);
    wb(1'b0, `IDX_STAT1, 32'h0);
    chk("flags", q, {26'h0, 2'b10, sk, nz, 2'b00});
    wb(1'b0, `IDX_DATA, 32'h0);
    chk("rx data", q, {24'h0, rx});
    wb(1'b0, `IDX_STAT1, 32'h0);
    chk("flags cleared", q, 32'h0);
    wb(1'b0, `IDX_IRQ_ST, 32'h0);
    chk("events", q, {29'h0, nz, 2'b11});
    irq_is(1'b0);
  endtask : field

  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // The whole run needs about seven thousand cycles.
  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h4194;
    n_errors = 0;
    n_tests = 0;
    {rst_i, cyc, stb, we, wait_mode, noisy, stuck} = 7'b1000000;
    {adr, wdat, resp} = '0;
    ro_regs = '{`IDX_BAUD, `IDX_MODE, `IDX_CTRL, `IDX_STAT1, `IDX_STAT2,
                `IDX_IRQ_ST, `IDX_IRQ_EN, 8'h10};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ro_regs[i]) begin
      wb(1'b0, ro_regs[i], 32'h0);
      chk("reset value", q, 32'h0);
    end
    wb(1'b1, `IDX_STAT2, 32'hff);
    wb(1'b0, `IDX_STAT2, 32'h0);
    chk("status read only", q, 32'h0);
    wb(1'b1, `IDX_BAUD, 32'h1);
    // Every delay code, with random push words and valid pull words.
    for (int d = 0; d < 4; d++) begin
      field(8'($random(seed)), {4'h5, 3'($random(seed)), 1'b1}, 1'b0,
            1'b0, 2'(d), d[0]);
      if (d == 0) begin
        wb(1'b1, `IDX_IRQ_EN, 32'h2);
        irq_is(1'b1);
        wb(1'b1, `IDX_IRQ_EN, 32'h0);
        irq_is(1'b0);
        wb(1'b1, `IDX_IRQ_EN, 32'h2);
        wb(1'b1, `IDX_IRQ_CLR, 32'h2);
        irq_is(1'b0);
        wb(1'b0, `IDX_IRQ_ST, 32'h0);
        chk("clear one event", q, 32'h1);
        wb(1'b1, `IDX_IRQ_EN, 32'h0);
      end
    end
    field(8'($random(seed)), 8'h43, 1'b0, 1'b0, 2'd3, 1'b0);
    field(8'($random(seed)), 8'h55, 1'b1, 1'b0, 2'd2, 1'b0);
    field(8'($random(seed)), 8'h55, 1'b0, 1'b1, 2'd1, 1'b0);
    // Halt in wait mode freezes the field until wait mode ends.
    stuck     <= 1'b0;
    wait_mode <= 1'b1;
    wb(1'b1, `IDX_IRQ_CLR, 32'h7);
    wb(1'b1, `IDX_MODE, 32'hc0);
    wb(1'b1, `IDX_DATA, 32'h5a);
    repeat (600) @(posedge clk_i);
    wb(1'b0, `IDX_IRQ_ST, 32'h0);
    chk("frozen", q, 32'h0);
    wait_mode <= 1'b0;
    repeat (600) @(posedge clk_i);
    wb(1'b0, `IDX_IRQ_ST, 32'h0);
    chk("resumed", q, 32'h3);
    wb(1'b0, `IDX_STAT1, 32'h0);
    wb(1'b0, `IDX_DATA, 32'h0);
    chk("resumed data", q, 32'h55);
    // A zero divisor freezes the field it starts in push; a cleared mode enable starts nothing.
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, `IDX_MODE, i ? 32'h0 : 32'h40);
      wb(1'b1, `IDX_BAUD, 32'(i));
      wb(1'b1, `IDX_IRQ_CLR, 32'h7);
      wb(1'b1, `IDX_DATA, 32'h3c);
      repeat (600) @(posedge clk_i);
      wb(1'b0, `IDX_IRQ_ST, 32'h0);
      chk("no field", q, 32'h0);
      chk("no drive", {31'h0, wire_oe}, 32'h0);
    end
    tally_and_finish();
  end
endmodule : wire_bus_port_tb
`default_nettype wire
